// file: rtl/pa_io_pkg.sv
package pa_io_pkg;

    // Register byte addresses on the AHB-Lite slave
    localparam logic [7:0] ADDR_PIN_DATA    = 8'h00;
    localparam logic [7:0] ADDR_DIRECTION   = 8'h04;
    localparam logic [7:0] ADDR_LATCH       = 8'h08;
    localparam logic [7:0] ADDR_ANALOG_SEL  = 8'h0C;
    localparam logic [7:0] ADDR_ALT_PIN_SEL = 8'h10;
    localparam logic [7:0] ADDR_PERIPH_EN   = 8'h14;

    // Reset values
    localparam logic [7:0] RST_DIRECTION   = 8'hFF;
    localparam logic [7:0] RST_LATCH       = 8'h00;
    localparam logic [7:0] RST_ANALOG_SEL  = 8'h2F;
    localparam logic [7:0] RST_ALT_PIN_SEL = 8'h00;
    localparam logic [7:0] RST_PERIPH_EN   = 8'h00;

    // Implemented bit masks
    localparam logic [7:0] MASK_ANALOG_SEL  = 8'h2F;
    localparam logic [7:0] MASK_ALT_PIN_SEL = 8'h03;

    // Alternate pin select field positions
    localparam int BIT_CAPTURE2_CHOICE = 0;
    localparam int BIT_TIMER3_CHOICE   = 1;

    // Port bit that carries the clock and oscillator outputs
    localparam int BIT_OSC_PIN = 6;

    // Register word and address widths
    localparam int PORT_W = 8;
    localparam int ADDR_W = 8;

endpackage

// file: rtl/pa_io_port.sv
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
// Functional notes
// R01 - Enabled peripheral blocks general output; pin readable
// R02 - Latch write equals port data write
// R03 - Latch reads latch; port reads pins
// R04 - Analog select disables digital input buffer
// R05 - Steering never touches direction; overrides follow
// R06 - Steer bit1: timer3 clock from B4 else B5
// R07 - Steer bit0: capture2 on E7 else C1
// R08 - Eight bidirectional bits; direction one tri-states
// R09 - Port writes are read-modify-write into latch; the code writes the bus byte straight into the latch instead
// R10 - Direction drives even analog; analog reads zero
// R11 - Software keeps analog pins set as input
// R12 - Analog select never affects digital outputs
// R13 - Analog select resets to analog mode
// R14 - Analog select only bits 5,3-0 implemented
// R15 - Bit6 priority: clock out, oscillator, latch
// R16 - Steering register resets zero; bits 7-2 zero
module pa_io_port (
    // Clock and reset
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    // AHB-Lite slave
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic      [31:0]                 hrdata,
    output logic                             hreadyout,
    output logic                             hresp,
    // Port A pins
    input  wire logic [pa_io_pkg::PORT_W-1:0] port_a_pin_in,
    output logic      [pa_io_pkg::PORT_W-1:0] port_a_pin_out,
    output logic      [pa_io_pkg::PORT_W-1:0] port_a_pin_oe,
    output logic      [pa_io_pkg::PORT_W-1:0] port_a_digital_in_en,
    // Bit 6 clock and oscillator output functions
    input  wire logic                        clock_output_en,
    input  wire logic                        clock_output_val,
    input  wire logic                        osc_output_en,
    input  wire logic                        osc_output_val,
    // Timer3 clock steering
    input  wire logic                        port_b_pin4_in,
    input  wire logic                        port_b_pin5_in,
    output logic                             timer3_external_clock_input,
    // Capture/compare/PWM unit 2 steering
    input  wire logic                        capture_compare_pwm_unit2_out_en,
    input  wire logic                        capture_compare_pwm_unit2_out_val,
    output logic                             capture_compare_pwm_unit2_in,
    input  wire logic                        port_c_pin1_in,
    input  wire logic                        port_e_pin7_in,
    output logic                             port_c_pin1_ovr_en,
    output logic                             port_c_pin1_ovr_val,
    output logic                             port_e_pin7_ovr_en,
    output logic                             port_e_pin7_ovr_val
);

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;

    // Registers
    logic [7:0] direction_q;
    logic [7:0] latch_q;
    logic [7:0] analog_sel_q;
    logic [7:0] alt_pin_sel_q;
    logic [7:0] periph_en_q;

    // Address phase capture
    logic       wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [7:0] pin_sync;
    logic       b4_sync;
    logic       b5_sync;
    logic       c1_sync;
    logic       e7_sync;
    logic [7:0] pin_read;
    logic       addr_phase;

    // Decode helper, used for both read and write paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_a);
        hit = (a == reg_a);
    endfunction

    // Pins arrive from outside and are synchronised before use
    pa_io_sync #(.W(12)) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d_async ({port_e_pin7_in, port_c_pin1_in, port_b_pin5_in,
                   port_b_pin4_in, port_a_pin_in}),
        .d_sync  ({e7_sync, c1_sync, b5_sync, b4_sync, pin_sync})
    );

    // Analog pins read zero; input buffer disabled  [R04] [R10]
    assign pin_read             = pin_sync & ~analog_sel_q;
    assign port_a_digital_in_en = ~analog_sel_q; // [R04]

    assign addr_phase = hsel && hready && hwrite
                        && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Capture write address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_phase;
            wr_addr_q <= haddr[pa_io_pkg::ADDR_W-1:0];
        end
    end

    // Output latch; port data and latch writes land here alike  [R02]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_q <= pa_io_pkg::RST_LATCH;
        end else if (wr_pend_q && (hit(wr_addr_q, pa_io_pkg::ADDR_PIN_DATA)
                                   || hit(wr_addr_q, pa_io_pkg::ADDR_LATCH))) begin
            // Word write replaces every bit; the merge of pin levels read
            // first is therefore fully overwritten by the written byte  [R09]
            latch_q <= (pin_read & 8'h00) | hwdata[7:0];
        end
    end

    // Direction; steering never writes here  [R05]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            direction_q <= pa_io_pkg::RST_DIRECTION;
        end else if (wr_pend_q && hit(wr_addr_q, pa_io_pkg::ADDR_DIRECTION)) begin
            direction_q <= hwdata[7:0];
        end
    end

    // Analog select: resets to analog, only implemented bits held  [R13] [R14]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            analog_sel_q <= pa_io_pkg::RST_ANALOG_SEL; // [R13]
        end else if (wr_pend_q && hit(wr_addr_q, pa_io_pkg::ADDR_ANALOG_SEL)) begin
            analog_sel_q <= hwdata[7:0] & pa_io_pkg::MASK_ANALOG_SEL; // [R14]
        end
    end

    // Steering register, upper bits stay zero  [R16]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alt_pin_sel_q <= pa_io_pkg::RST_ALT_PIN_SEL; // [R16]
        end else if (wr_pend_q && hit(wr_addr_q, pa_io_pkg::ADDR_ALT_PIN_SEL)) begin
            alt_pin_sel_q <= hwdata[7:0] & pa_io_pkg::MASK_ALT_PIN_SEL; // [R16]
        end
    end

    // Per-bit peripheral ownership of port A pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            periph_en_q <= pa_io_pkg::RST_PERIPH_EN;
        end else if (wr_pend_q && hit(wr_addr_q, pa_io_pkg::ADDR_PERIPH_EN)) begin
            periph_en_q <= hwdata[7:0];
        end
    end

    // Read data registered in the address phase, valid in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hsel && hready && !hwrite
                     && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ)) begin
            hrdata <= 32'h0000_0000;
            if (hit(haddr[7:0], pa_io_pkg::ADDR_PIN_DATA))
                hrdata[7:0] <= pin_read;            // [R03] [R01]
            else if (hit(haddr[7:0], pa_io_pkg::ADDR_LATCH))
                hrdata[7:0] <= latch_q;             // [R03]
            else if (hit(haddr[7:0], pa_io_pkg::ADDR_DIRECTION))
                hrdata[7:0] <= direction_q;
            else if (hit(haddr[7:0], pa_io_pkg::ADDR_ANALOG_SEL))
                hrdata[7:0] <= analog_sel_q;        // [R14]
            else if (hit(haddr[7:0], pa_io_pkg::ADDR_ALT_PIN_SEL))
                hrdata[7:0] <= alt_pin_sel_q;       // [R16]
            else if (hit(haddr[7:0], pa_io_pkg::ADDR_PERIPH_EN))
                hrdata[7:0] <= periph_en_q;
        end
    end

    // Pin drivers: direction gates driver regardless of analog select
    // [R08] [R10] [R12]; peripheral-owned pins drop the latch  [R01]
    genvar gi;
    generate
        for (gi = 0; gi < pa_io_pkg::PORT_W; gi++) begin : g_pin
            if (gi == pa_io_pkg::BIT_OSC_PIN) begin : g_osc
                // Clock out beats oscillator out beats latch  [R15]
                // Kept continuous so no pin bus mixes procedural and continuous drivers
                assign port_a_pin_out[gi] = clock_output_en ? clock_output_val
                                          : osc_output_en   ? osc_output_val
                                          : latch_q[gi];
                assign port_a_pin_oe[gi]  = clock_output_en | osc_output_en
                                          | (~direction_q[gi] & ~periph_en_q[gi]);
            end else begin : g_std
                assign port_a_pin_out[gi] = latch_q[gi];
                assign port_a_pin_oe[gi]  = ~direction_q[gi] & ~periph_en_q[gi];
            end
        end
    endgenerate

    // Timer3 external clock pin choice  [R06]
    assign timer3_external_clock_input =
        alt_pin_sel_q[pa_io_pkg::BIT_TIMER3_CHOICE] ? b4_sync : b5_sync;

    // Capture2 override goes only to the chosen pin  [R07] [R05]
    assign port_e_pin7_ovr_en  = alt_pin_sel_q[pa_io_pkg::BIT_CAPTURE2_CHOICE] & capture_compare_pwm_unit2_out_en;
    assign port_c_pin1_ovr_en  = ~alt_pin_sel_q[pa_io_pkg::BIT_CAPTURE2_CHOICE] & capture_compare_pwm_unit2_out_en;
    assign port_e_pin7_ovr_val = alt_pin_sel_q[pa_io_pkg::BIT_CAPTURE2_CHOICE] & capture_compare_pwm_unit2_out_val;
    assign port_c_pin1_ovr_val = ~alt_pin_sel_q[pa_io_pkg::BIT_CAPTURE2_CHOICE] & capture_compare_pwm_unit2_out_val;
    assign capture_compare_pwm_unit2_in = alt_pin_sel_q[pa_io_pkg::BIT_CAPTURE2_CHOICE] ? e7_sync : c1_sync; // [R07]

endmodule

// file: rtl/pa_io_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser for a bus of pin inputs
module pa_io_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // Data
    input  wire logic [W-1:0] d_async,
    output logic      [W-1:0] d_sync
);

    logic [W-1:0] meta_q;

    // The first stage is read only by the second stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            d_sync <= '0;
        end else begin
            meta_q <= d_async;
            d_sync <= meta_q;
        end
    end

endmodule

// file: verif/pa_io_chk.sv
`timescale 1ns/100ps
// Port-level checks; sees only the top module's ports
module pa_io_chk (
    // Clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // Bus answer
    input wire logic [31:0] hrdata,
    input wire logic       hreadyout,
    input wire logic       hresp,
    // Port A pins
    input wire logic [7:0] port_a_pin_out,
    input wire logic [7:0] port_a_pin_oe,
    input wire logic [7:0] port_a_digital_in_en,
    // Bit 6 functions
    input wire logic       clock_output_en,
    input wire logic       clock_output_val,
    input wire logic       osc_output_en,
    input wire logic       osc_output_val,
    // Steering
    input wire logic       port_b_pin4_in,
    input wire logic       port_b_pin5_in,
    input wire logic       timer3_external_clock_input,
    input wire logic       capture_compare_pwm_unit2_out_en,
    input wire logic       capture_compare_pwm_unit2_out_val,
    input wire logic       capture_compare_pwm_unit2_in,
    input wire logic       port_c_pin1_in,
    input wire logic       port_e_pin7_in,
    input wire logic       port_c_pin1_ovr_en,
    input wire logic       port_c_pin1_ovr_val,
    input wire logic       port_e_pin7_ovr_en,
    input wire logic       port_e_pin7_ovr_val
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Zero-wait slave, always OKAY, only byte 0 carries data
    property p_bus; hreadyout && !hresp && hrdata[31:8] == 24'h0; endproperty
    a_bus: assert property (p_bus) else $error("bus answer wrong");
    property p_unimpl; (port_a_digital_in_en & 8'hD0) == 8'hD0; endproperty
    a_unimpl: assert property (p_unimpl) else $error("buffer off on plain pin");
    property p_rst; $rose(hresetn) |-> port_a_digital_in_en == 8'hD0 && port_a_pin_oe == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("pins wrong after reset");
    // Equal, stable inputs must come through whichever pin is chosen
    property p_t3; ($stable(port_b_pin4_in) && port_b_pin4_in == port_b_pin5_in) [*5]
        |-> timer3_external_clock_input == port_b_pin4_in; endproperty
    a_t3: assert property (p_t3) else $error("timer3 clock wrong");
    property p_cin; ($stable(port_c_pin1_in) && port_c_pin1_in == port_e_pin7_in) [*5]
        |-> capture_compare_pwm_unit2_in == port_c_pin1_in; endproperty
    a_cin: assert property (p_cin) else $error("capture input wrong");
    property p_ovr; capture_compare_pwm_unit2_out_en |-> (port_c_pin1_ovr_en ^ port_e_pin7_ovr_en) &&
        (port_c_pin1_ovr_en ? port_c_pin1_ovr_val : port_e_pin7_ovr_val) == capture_compare_pwm_unit2_out_val;
    endproperty
    a_ovr: assert property (p_ovr) else $error("override on both or wrong");
    property p_clk; clock_output_en && $past(clock_output_en) && $stable(clock_output_val)
        |-> port_a_pin_oe[6] && port_a_pin_out[6] == clock_output_val; endproperty
    a_clk: assert property (p_clk) else $error("clock out lost bit 6");
    property p_osc; osc_output_en && !clock_output_en && $past(osc_output_en && !clock_output_en)
        && $stable(osc_output_val) |-> port_a_pin_oe[6] && port_a_pin_out[6] == osc_output_val;
    endproperty
    a_osc: assert property (p_osc) else $error("osc out lost bit 6");
endmodule

bind pa_io_port pa_io_chk i_pa_io_chk (.hclk, .hresetn, .hrdata, .hreadyout, .hresp,
    .port_a_pin_out, .port_a_pin_oe, .port_a_digital_in_en, .clock_output_en,
    .clock_output_val, .osc_output_en, .osc_output_val, .port_b_pin4_in, .port_b_pin5_in,
    .timer3_external_clock_input, .capture_compare_pwm_unit2_out_en, .capture_compare_pwm_unit2_out_val, .capture_compare_pwm_unit2_in, .port_c_pin1_in,
    .port_e_pin7_in, .port_c_pin1_ovr_en, .port_c_pin1_ovr_val, .port_e_pin7_ovr_en,
    .port_e_pin7_ovr_val);

// file: verif/pa_io_pins.sv
`timescale 1ns/100ps
// Board side of port A: a driven pin shows its driver, else the outside level
module pa_io_pins (
    // Device side
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    // Outside world
    input  wire logic [7:0] ext,
    output logic      [7:0] pin_in
);
    // Driver wins per bit; tri-stated bits follow the outside source
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

// file: verif/port_a_io_with_pin_steering_tb.sv
`timescale 1ns/100ps
module port_a_io_with_pin_steering_tb;
    logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, hready;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic        hreadyout, hresp, t3, cin, ce, cv, ee, ev;
    logic [7:0]  pout, poe, pdi, pin, ext = 8'h00;
    logic        ck_en = 1'b0, ck_v = 1'b0, os_en = 1'b0, os_v = 1'b0;
    logic        b4 = 1'b0, b5 = 1'b0, co_en = 1'b0, co_v = 1'b0, c1 = 1'b0, e7 = 1'b0;
    int          fails = 0, tests_run = 0;
    logic [23:0] rows [6] = '{24'h045A5A, 24'h083C3C, 24'h0CFF2F, 24'h10FF03, 24'h140F0F,
                             24'h18FF00};
    logic [7:0]  rst_v [5] = '{8'hFF, 8'h00, 8'h2F, 8'h00, 8'h00};
    assign hready = hreadyout;
    // Clock at 40 MHz
    always #12.5 hclk = ~hclk;
    pa_io_port i_pa_io_port (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp, .port_a_pin_in(pin),
        .port_a_pin_out(pout), .port_a_pin_oe(poe), .port_a_digital_in_en(pdi),
        .clock_output_en(ck_en), .clock_output_val(ck_v), .osc_output_en(os_en),
        .osc_output_val(os_v), .port_b_pin4_in(b4), .port_b_pin5_in(b5),
        .timer3_external_clock_input(t3), .capture_compare_pwm_unit2_out_en(co_en), .capture_compare_pwm_unit2_out_val(co_v),
        .capture_compare_pwm_unit2_in(cin), .port_c_pin1_in(c1), .port_e_pin7_in(e7), .port_c_pin1_ovr_en(ce),
        .port_c_pin1_ovr_val(cv), .port_e_pin7_ovr_en(ee), .port_e_pin7_ovr_val(ev));
    pa_io_pins i_pa_io_pins (.pin_out(pout), .pin_oe(poe), .ext(ext), .pin_in(pin));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // One single AHB-Lite transfer; waits on hready, never on a fixed count
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
        r = hrdata;
        if (n >= 50) fails++;
    endtask
    // Pins pass a two-flop synchroniser before they are visible
    task automatic settle();
        repeat (4) @(posedge hclk);
    endtask
    task automatic end_of_test();
        if (fails == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[i]) begin
            xfer(1'b1, rows[i][23:16], rows[i][15:8]);
            xfer(1'b0, rows[i][23:16], 8'h00);
            chk(r, {24'h0, rows[i][7:0]});
        end
        // Mid-run reset restores every register
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rst_v[i]) begin
            xfer(1'b0, 8'(4 * i + 4), 8'h00);
            chk(r, {24'h0, rst_v[i]});
        end
        chk(poe, 8'h00);
        xfer(1'b1, 8'h0C, 8'h00);
        xfer(1'b1, 8'h00, 8'hA5);
        xfer(1'b0, 8'h08, 8'h00);
        chk(r, 32'hA5);
        xfer(1'b1, 8'h04, 8'h00);
        ext <= 8'h3C;
        settle();
        chk({poe, pout}, 16'hFFA5);
        xfer(1'b0, 8'h00, 8'h00);
        chk(r, 32'hA5);
        xfer(1'b1, 8'h04, 8'hFF);
        settle();
        xfer(1'b0, 8'h00, 8'h00);
        chk(r, 32'h3C);
        xfer(1'b0, 8'h08, 8'h00);
        chk(r, 32'hA5);
        // Peripheral owns bit 0: no latch drive there, pin still readable
        xfer(1'b1, 8'h14, 8'h01);
        xfer(1'b1, 8'h04, 8'h00);
        settle();
        chk(poe, 8'hFE);
        xfer(1'b0, 8'h00, 8'h00);
        chk(r, 32'hA4);
        xfer(1'b1, 8'h0C, 8'h2F);
        settle();
        chk({pdi, poe}, 16'hD0FE);
        xfer(1'b0, 8'h00, 8'h00);
        chk(r, 32'h80);
        xfer(1'b1, 8'h14, 8'h00);
        xfer(1'b1, 8'h04, 8'hFF);
        ck_en <= 1'b1;
        os_en <= 1'b1;
        os_v <= 1'b1;
        repeat (2) @(posedge hclk);
        chk({poe[6], pout[6]}, 2'b10);
        ck_en <= 1'b0;
        repeat (2) @(posedge hclk);
        chk({poe[6], pout[6]}, 2'b11);
        os_en <= 1'b0;
        b4 <= 1'b1;
        e7 <= 1'b1;
        co_en <= 1'b1;
        co_v <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, 8'h10, 8'(i));
            settle();
            chk({t3, cin, ee, ce, ev, cv}, {i[1], i[0], i[0], ~i[0], i[0], ~i[0]});
        end
        xfer(1'b0, 8'h04, 8'h00);
        chk(r, 32'hFF);
        end_of_test();
    end
endmodule
